// File: src/geom_regs.vh
// register map and constants of the image geometry stage
//
// Overview of operation
// - horizontal mirror reverses column order per frame
// - region of interest cropped from mirrored frame
// - horizontal mirror swaps bayer phase left-right
// - vertical mirror reverses row order per frame
// - vertical mirror swaps bayer phase top-bottom
// - read-only sensor column and row counts
// - max columns equals sensor width over binning, or over decimation when that is above 1
// - max rows equals sensor height over binning, or over decimation when that is above 1
// - output frame matches configured width, height
// - region placed at configured column, row offsets
// - read-only bits per output pixel
// - colour filter only for bayer, else none
// - read-only darkest digitized value
// - read-only brightest digitized value
// - enable routes 8-bit mono and bayer pixels through processing core, other formats pass unchanged
// - selector picks binning engine for factors
// - row merge factor shrinks width, 1 none
// - column merge factor shrinks height, 1 none
// - binning acts only while decimation is 1
`ifndef GEOM_REGS_VH
`define GEOM_REGS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_ROI_W 8'h04
`define OFS_ROI_H 8'h08
`define OFS_ROI_COL 8'h0C
`define OFS_ROI_ROW 8'h10
`define OFS_ROW_MERGE 8'h14
`define OFS_COL_MERGE 8'h18
`define OFS_HDEC 8'h1C
`define OFS_VDEC 8'h20
`define OFS_PIXFMT 8'h24
`define OFS_SENSOR_W 8'h28
`define OFS_SENSOR_H 8'h2C
`define OFS_MAX_COLS 8'h30
`define OFS_MAX_ROWS 8'h34
`define OFS_PIX_SIZE 8'h38
`define OFS_FILTER 8'h3C
`define OFS_DYN_MIN 8'h40
`define OFS_DYN_MAX 8'h44
`define OFS_STATUS 8'h48

// ----------------------------------------
// control fields
// ----------------------------------------
`define CTRL_MIRROR_X 0
`define CTRL_MIRROR_Y 1
`define CTRL_CORE_EN 2
`define CTRL_BIN_SEL 3

// ----------------------------------------
// reset values and fixed figures
// ----------------------------------------
`define SENSOR_W 11'h500
`define SENSOR_H 11'h400
`define ROI_W_RST 11'h500
`define ROI_H_RST 11'h400
`define FACTOR_RST 3'h1
`define FMT_RST 4'h0
`define DYN_MIN 16'h0000
`define DYN_MAX8 16'h00FF
`define DYN_MAX16 16'hFFF0

// ----------------------------------------
// pixel formats and filter codes
// ----------------------------------------
`define FMT_MONO8 4'h0
`define FMT_MONO16 4'h1
`define FMT_RGB8 4'h2
`define FMT_BAYER_FIRST 4'h3
`define FMT_BAYER_LAST 4'h8
`define FMT_BAYER16_FIRST 4'h7
`define FILTER_NONE 3'h0
`define PHASE_RG 2'h0

`endif

// File: src/coord_map.v
// maps an output index to a sensor coordinate on one axis
`timescale 1ns/10ps
module coord_map (
  // output position
  input wire [10:0] pos_i,
  input wire [3:0] sub_i,
  // axis settings
  input wire [10:0] start_i,
  input wire [10:0] max_i,
  input wire mirror_i,
  input wire [2:0] shift_i,
  // sensor coordinate
  output wire [10:0] sensor_o
);
  wire [10:0] binned;
  wire [10:0] flipped;
  wire [10:0] scaled;

  assign binned = start_i + pos_i;
  assign flipped = mirror_i ? (max_i - 11'h001 - binned) : binned;
  assign scaled = flipped << shift_i;
  assign sensor_o = scaled + {7'h00, sub_i};
endmodule

// File: src/image_flip_roi_binning.v
// image geometry stage: mirror, crop, binning and format info
`timescale 1ns/10ps
`include "geom_regs.vh"
module image_flip_roi_binning #(
  parameter COLOUR_SENSOR = 1'b1,
  parameter [1:0] NATIVE_PHASE = `PHASE_RG
) (
  // clock, reset, enable
  input wire clk_i,
  input wire rst_n_i,
  input wire ce_i,
  // apb slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  // frame control
  input wire frame_start_i,
  output wire busy_o,
  // sensor fetch
  output wire fetch_valid_o,
  output reg [10:0] fetch_col_o,
  output reg [10:0] fetch_row_o,
  input wire fetch_ready_i,
  input wire pix_valid_i,
  input wire [15:0] pix_data_i,
  // output stream
  output wire out_valid_o,
  output reg [15:0] out_data_o,
  output wire out_sof_o,
  output wire out_eol_o,
  output wire out_eof_o,
  input wire out_ready_i
);
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_ADDR = 5'h02;
  localparam [4:0] S_REQ = 5'h04;
  localparam [4:0] S_WAIT = 5'h08;
  localparam [4:0] S_OUT = 5'h10;

  // ----------------------------------------
  // decoding helpers
  // ----------------------------------------
  // factors other than 1, 2, 4 act as 1
  function [2:0] fac_shift;
    input [2:0] f;
    begin
      case (f)
        3'h2: fac_shift = 3'h1;
        3'h4: fac_shift = 3'h2;
        default: fac_shift = 3'h0;
      endcase
    end
  endfunction

  function is_bayer;
    input [3:0] f;
    begin
      is_bayer = (f >= `FMT_BAYER_FIRST) && (f <= `FMT_BAYER_LAST);
    end
  endfunction

  function is_8bit;
    input [3:0] f;
    begin
      is_8bit = (f == `FMT_MONO8) || (is_bayer(f) && (f < `FMT_BAYER16_FIRST));
    end
  endfunction

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  reg [3:0] ctrl_reg;
  reg [10:0] roi_w_reg;
  reg [10:0] roi_h_reg;
  reg [10:0] roi_column_start_reg;
  reg [10:0] roi_row_start_reg;
  reg [2:0] row_merge_factor_reg [0:1];
  reg [2:0] column_merge_factor_reg [0:1];
  reg [2:0] hdec_reg;
  reg [2:0] vdec_reg;
  reg [3:0] fmt_reg;

  wire bin_sel = ctrl_reg[`CTRL_BIN_SEL];
  // both engines in series, each 1, 2 or 4
  wire [2:0] hbin_shift = fac_shift(row_merge_factor_reg[0]) + fac_shift(row_merge_factor_reg[1]);
  wire [2:0] vbin_shift = fac_shift(column_merge_factor_reg[0]) + fac_shift(column_merge_factor_reg[1]);
  wire hbin_on = (hdec_reg == 3'h1);
  wire vbin_on = (vdec_reg == 3'h1);
  wire [2:0] h_shift = hbin_on ? hbin_shift : fac_shift(hdec_reg);
  wire [2:0] v_shift = vbin_on ? vbin_shift : fac_shift(vdec_reg);
  wire [10:0] max_image_columns = `SENSOR_W >> h_shift;
  wire [10:0] max_image_rows = `SENSOR_H >> v_shift;

  // ----------------------------------------
  // active frame settings
  // ----------------------------------------
  reg [4:0] state_reg;
  reg [3:0] sh_ctrl;
  reg [10:0] sh_w;
  reg [10:0] sh_h;
  reg [10:0] sh_col;
  reg [10:0] sh_row;
  reg [10:0] sh_maxc;
  reg [10:0] sh_maxr;
  reg [2:0] sh_hshift;
  reg [2:0] sh_vshift;
  reg [3:0] sh_hsub_last;
  reg [3:0] sh_vsub_last;
  reg [3:0] sh_avg;
  reg [3:0] sh_fmt;
  wire [1:0] out_phase = NATIVE_PHASE ^ {sh_ctrl[`CTRL_MIRROR_Y] ^ sh_row[0], sh_ctrl[`CTRL_MIRROR_X] ^ sh_col[0]};
  wire [2:0] filter_code = (COLOUR_SENSOR && is_bayer(sh_fmt)) ? {1'b0, out_phase} + 3'h1 : `FILTER_NONE;
  wire [5:0] pix_size = (fmt_reg == `FMT_RGB8) ? 6'h18 : (is_8bit(fmt_reg) ? 6'h08 : 6'h10);

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  reg addr_ok;
  reg [31:0] rd_next;
  wire setup = psel_i & ~penable_i;
  wire access = psel_i & penable_i;

  always @*
  begin
    addr_ok = 1'b1;
    rd_next = 32'h0000_0000;
    case (paddr_i)
      `OFS_CTRL: rd_next[3:0] = ctrl_reg;
      `OFS_ROI_W: rd_next[10:0] = roi_w_reg;
      `OFS_ROI_H: rd_next[10:0] = roi_h_reg;
      `OFS_ROI_COL: rd_next[10:0] = roi_column_start_reg;
      `OFS_ROI_ROW: rd_next[10:0] = roi_row_start_reg;
      `OFS_ROW_MERGE: rd_next[2:0] = row_merge_factor_reg[bin_sel];
      `OFS_COL_MERGE: rd_next[2:0] = column_merge_factor_reg[bin_sel];
      `OFS_HDEC: rd_next[2:0] = hdec_reg;
      `OFS_VDEC: rd_next[2:0] = vdec_reg;
      `OFS_PIXFMT: rd_next[3:0] = fmt_reg;
      `OFS_SENSOR_W: rd_next[10:0] = `SENSOR_W;
      `OFS_SENSOR_H: rd_next[10:0] = `SENSOR_H;
      `OFS_MAX_COLS: rd_next[10:0] = max_image_columns;
      `OFS_MAX_ROWS: rd_next[10:0] = max_image_rows;
      `OFS_PIX_SIZE: rd_next[5:0] = pix_size;
      `OFS_FILTER: rd_next[2:0] = filter_code;
      `OFS_DYN_MIN: rd_next[15:0] = `DYN_MIN;
      `OFS_DYN_MAX: rd_next[15:0] = (is_8bit(fmt_reg) || (fmt_reg == `FMT_RGB8)) ? `DYN_MAX8 : `DYN_MAX16;
      `OFS_STATUS: rd_next[0] = ~state_reg[0];
      default: addr_ok = 1'b0;
    endcase
  end

  // zero wait states
  assign pready_o = 1'b1;
  assign pslverr_o = access & ~addr_ok;

  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      prdata_o <= 32'h0000_0000;
      ctrl_reg <= 4'h0;
      roi_w_reg <= `ROI_W_RST;
      roi_h_reg <= `ROI_H_RST;
      roi_column_start_reg <= 11'h000;
      roi_row_start_reg <= 11'h000;
      row_merge_factor_reg[0] <= `FACTOR_RST;
      row_merge_factor_reg[1] <= `FACTOR_RST;
      column_merge_factor_reg[0] <= `FACTOR_RST;
      column_merge_factor_reg[1] <= `FACTOR_RST;
      hdec_reg <= `FACTOR_RST;
      vdec_reg <= `FACTOR_RST;
      fmt_reg <= `FMT_RST;
    end
    else if (ce_i)
    begin
      // read data settles during the setup cycle
      if (setup)
        prdata_o <= (pwrite_i || !addr_ok) ? 32'h0000_0000 : rd_next;
      if (access && pwrite_i)
      begin
        case (paddr_i)
          `OFS_CTRL: ctrl_reg <= pwdata_i[3:0];
          `OFS_ROI_W: roi_w_reg <= pwdata_i[10:0];
          `OFS_ROI_H: roi_h_reg <= pwdata_i[10:0];
          `OFS_ROI_COL: roi_column_start_reg <= pwdata_i[10:0];
          `OFS_ROI_ROW: roi_row_start_reg <= pwdata_i[10:0];
          `OFS_ROW_MERGE: row_merge_factor_reg[bin_sel] <= pwdata_i[2:0];
          `OFS_COL_MERGE: column_merge_factor_reg[bin_sel] <= pwdata_i[2:0];
          `OFS_HDEC: hdec_reg <= pwdata_i[2:0];
          `OFS_VDEC: vdec_reg <= pwdata_i[2:0];
          `OFS_PIXFMT: fmt_reg <= pwdata_i[3:0];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // coordinate mapping
  // ----------------------------------------
  reg [10:0] ox_reg;
  reg [10:0] oy_reg;
  reg [3:0] sx_reg;
  reg [3:0] sy_reg;
  reg [23:0] acc_reg;
  wire [10:0] map_col;
  wire [10:0] map_row;
  coord_map u_map_x (
    .pos_i(ox_reg),
    .sub_i(sx_reg),
    .start_i(sh_col),
    .max_i(sh_maxc),
    .mirror_i(sh_ctrl[`CTRL_MIRROR_X]),
    .shift_i(sh_hshift),
    .sensor_o(map_col)
  );
  coord_map u_map_y (
    .pos_i(oy_reg),
    .sub_i(sy_reg),
    .start_i(sh_row),
    .max_i(sh_maxr),
    .mirror_i(sh_ctrl[`CTRL_MIRROR_Y]),
    .shift_i(sh_vshift),
    .sensor_o(map_row)
  );

  // ----------------------------------------
  // frame sequencer
  // ----------------------------------------
  wire last_sub = (sx_reg == sh_hsub_last) && (sy_reg == sh_vsub_last);
  wire last_col = (ox_reg == sh_w - 11'h001);
  wire last_row = (oy_reg == sh_h - 11'h001);
  wire [23:0] sum = acc_reg + {8'h00, pix_data_i};
  wire [23:0] avg = sum >> sh_avg;

  assign busy_o = ~state_reg[0];
  assign fetch_valid_o = state_reg[2];
  assign out_valid_o = state_reg[4];
  assign out_sof_o = out_valid_o && (ox_reg == 11'h000) && (oy_reg == 11'h000);
  assign out_eol_o = out_valid_o && last_col;
  assign out_eof_o = out_eol_o && last_row;

  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= S_IDLE;
      sh_ctrl <= 4'h0;
      sh_w <= `ROI_W_RST;
      sh_h <= `ROI_H_RST;
      sh_col <= 11'h000;
      sh_row <= 11'h000;
      sh_maxc <= `SENSOR_W;
      sh_maxr <= `SENSOR_H;
      sh_hshift <= 3'h0;
      sh_vshift <= 3'h0;
      sh_hsub_last <= 4'h0;
      sh_vsub_last <= 4'h0;
      sh_avg <= 4'h0;
      sh_fmt <= `FMT_RST;
      ox_reg <= 11'h000;
      oy_reg <= 11'h000;
      sx_reg <= 4'h0;
      sy_reg <= 4'h0;
      acc_reg <= 24'h000000;
      fetch_col_o <= 11'h000;
      fetch_row_o <= 11'h000;
      out_data_o <= 16'h0000;
    end
    else if (ce_i)
    begin
      case (state_reg)
        S_IDLE:
        begin
          if (frame_start_i)
          begin
            sh_ctrl <= ctrl_reg;
            sh_w <= roi_w_reg;
            sh_h <= roi_h_reg;
            sh_col <= roi_column_start_reg;
            sh_row <= roi_row_start_reg;
            sh_maxc <= max_image_columns;
            sh_maxr <= max_image_rows;
            sh_hshift <= h_shift;
            sh_vshift <= v_shift;
            // decimation keeps one cell, binning merges all
            sh_hsub_last <= hbin_on ? (4'h1 << hbin_shift) - 4'h1 : 4'h0;
            sh_vsub_last <= vbin_on ? (4'h1 << vbin_shift) - 4'h1 : 4'h0;
            sh_avg <= {1'b0, hbin_on ? hbin_shift : 3'h0} + {1'b0, vbin_on ? vbin_shift : 3'h0};
            sh_fmt <= fmt_reg;
            ox_reg <= 11'h000;
            oy_reg <= 11'h000;
            sx_reg <= 4'h0;
            sy_reg <= 4'h0;
            acc_reg <= 24'h000000;
            state_reg <= S_ADDR;
          end
        end
        S_ADDR:
        begin
          fetch_col_o <= map_col;
          fetch_row_o <= map_row;
          state_reg <= S_REQ;
        end
        S_REQ:
        begin
          if (fetch_ready_i)
            state_reg <= S_WAIT;
        end
        S_WAIT:
        begin
          if (pix_valid_i)
          begin
            if (last_sub)
            begin
              acc_reg <= 24'h000000;
              sx_reg <= 4'h0;
              sy_reg <= 4'h0;
              out_data_o <= (sh_ctrl[`CTRL_CORE_EN] && is_8bit(sh_fmt)) ? {8'h00, avg[15:8]} : avg[15:0];
              state_reg <= S_OUT;
            end
            else
            begin
              acc_reg <= sum;
              sx_reg <= (sx_reg == sh_hsub_last) ? 4'h0 : sx_reg + 4'h1;
              sy_reg <= (sx_reg == sh_hsub_last) ? sy_reg + 4'h1 : sy_reg;
              state_reg <= S_ADDR;
            end
          end
        end
        S_OUT:
        begin
          if (out_ready_i)
          begin
            ox_reg <= last_col ? 11'h000 : ox_reg + 11'h001;
            oy_reg <= last_col ? oy_reg + 11'h001 : oy_reg;
            state_reg <= (last_col && last_row) ? S_IDLE : S_ADDR;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule

// File: tb/sensor_model.sv
// behavioural image sensor answering cell fetches
`timescale 1ns/10ps
module sensor_model (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // answer pacing
  input wire [3:0] lag_i,
  // fetch port
  input wire fetch_valid_i,
  input wire [10:0] fetch_col_i,
  input wire [10:0] fetch_row_i,
  output reg fetch_ready_o,
  output reg pix_valid_o,
  output reg [15:0] pix_data_o
);
  reg [3:0] wait_reg;
  always @(posedge clk_i)
  begin
    pix_valid_o <= 1'b0;
    fetch_ready_o <= 1'b0;
    // stale data scrambled so nobody relies on it
    pix_data_o <= ~pix_data_o;
    if (!rst_n_i)
    begin
      wait_reg <= 4'h0;
      pix_data_o <= 16'h0000;
    end
    else if (fetch_valid_i && fetch_ready_o)
    begin
      // cell value names its own coordinate
      pix_valid_o <= 1'b1;
      pix_data_o <= {fetch_col_i[7:0], fetch_row_i[7:0]};
      wait_reg <= 4'h0;
    end
    else if (fetch_valid_i)
    begin
      wait_reg <= wait_reg + 4'h1;
      fetch_ready_o <= (wait_reg >= lag_i);
    end
  end
endmodule

// File: tb/geom_chk.sv
// concurrent checks on the geometry stage ports
`timescale 1ns/10ps
module geom_chk (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // apb and frame control
  input wire psel_i,
  input wire penable_i,
  input wire [7:0] paddr_i,
  input wire pready_o,
  input wire pslverr_o,
  input wire frame_start_i,
  input wire busy_o,
  // fetch and output streams
  input wire fetch_valid_o,
  input wire [10:0] fetch_col_o,
  input wire [10:0] fetch_row_o,
  input wire fetch_ready_i,
  input wire out_valid_o,
  input wire [15:0] out_data_o,
  input wire out_sof_o,
  input wire out_eol_o,
  input wire out_eof_o,
  input wire out_ready_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  ready_now_a: assert property (psel_i |-> pready_o)
    else $error("pready low");
  err_high_a: assert property (psel_i && penable_i && paddr_i > 8'h48 |-> pslverr_o)
    else $error("missing slave error");
  err_low_a: assert property (pslverr_o |-> psel_i && penable_i && (paddr_i > 8'h48 || paddr_i[1:0] != 2'h0))
    else $error("false slave error");
  start_fetch_a: assert property (frame_start_i && !busy_o |=> busy_o ##1 fetch_valid_o)
    else $error("frame start not followed by fetch");
  fetch_hold_a: assert property (fetch_valid_o && !fetch_ready_i |=> fetch_valid_o && $stable({fetch_col_o, fetch_row_o}))
    else $error("fetch request changed");
  out_hold_a: assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable({out_data_o, out_eol_o, out_eof_o}))
    else $error("output changed while stalled");
  flag_qual_a: assert property (out_sof_o || out_eol_o || out_eof_o |-> out_valid_o)
    else $error("flag without valid");
  eof_eol_a: assert property (out_eof_o |-> out_eol_o)
    else $error("frame end not at line end");
  frame_end_a: assert property (out_valid_o && out_ready_i && out_eof_o |=> !busy_o ##1 !fetch_valid_o)
    else $error("busy after last pixel");
  idle_quiet_a: assert property (!busy_o |-> !fetch_valid_o && !out_valid_o)
    else $error("traffic while idle");
  cover property (out_valid_o && out_ready_i && out_eof_o);
  cover property (fetch_valid_o && !fetch_ready_i);
  cover property (pslverr_o);
endmodule
bind image_flip_roi_binning geom_chk chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .paddr_i(paddr_i), .pready_o(pready_o), .pslverr_o(pslverr_o), .frame_start_i(frame_start_i), .busy_o(busy_o),
  .fetch_valid_o(fetch_valid_o), .fetch_col_o(fetch_col_o), .fetch_row_o(fetch_row_o), .fetch_ready_i(fetch_ready_i),
  .out_valid_o(out_valid_o), .out_data_o(out_data_o), .out_sof_o(out_sof_o), .out_eol_o(out_eol_o),
  .out_eof_o(out_eof_o), .out_ready_i(out_ready_i));

// File: tb/image_flip_roi_binning_bench.sv
// self-checking bench for the image geometry stage
`timescale 1ns/10ps
`include "geom_regs.vh"
module image_flip_roi_binning_bench;
  reg clk_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg psel_i = 1'b0;
  reg penable_i = 1'b0;
  reg pwrite_i = 1'b0;
  reg [7:0] paddr_i = 8'h00;
  reg [31:0] pwdata_i = 32'h0;
  reg frame_start_i = 1'b0;
  reg out_ready_i = 1'b1;
  reg ce_i = 1'b1;
  reg stall = 1'b0;
  reg [3:0] lag = 4'h0;
  wire [31:0] prdata_o;
  wire [10:0] fetch_col_o, fetch_row_o;
  wire [15:0] pix_data_i, out_data_o;
  wire pready_o, pslverr_o, busy_o, fetch_valid_o, fetch_ready_i, pix_valid_i;
  wire out_valid_o, out_sof_o, out_eol_o, out_eof_o;
  integer mismatches = 0;
  integer cmp_count = 0;
  integer n_got = 0;
  reg [18:0] got [0:63];
  reg [31:0] rdv;
  reg errv;
  initial forever #5 clk_i = ~clk_i;
  image_flip_roi_binning dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .frame_start_i(frame_start_i), .busy_o(busy_o),
    .fetch_valid_o(fetch_valid_o), .fetch_col_o(fetch_col_o), .fetch_row_o(fetch_row_o),
    .fetch_ready_i(fetch_ready_i), .pix_valid_i(pix_valid_i), .pix_data_i(pix_data_i), .out_valid_o(out_valid_o),
    .out_data_o(out_data_o), .out_sof_o(out_sof_o), .out_eol_o(out_eol_o), .out_eof_o(out_eof_o),
    .out_ready_i(out_ready_i));
  sensor_model sensor (.clk_i(clk_i), .rst_n_i(rst_n_i), .lag_i(lag), .fetch_valid_i(fetch_valid_o),
    .fetch_col_i(fetch_col_o), .fetch_row_i(fetch_row_o), .fetch_ready_o(fetch_ready_i),
    .pix_valid_o(pix_valid_i), .pix_data_o(pix_data_i));
  always @(posedge clk_i)
  begin
    out_ready_i <= stall ? ~out_ready_i : 1'b1;
    if (out_valid_o && out_ready_i && n_got < 64)
    begin
      got[n_got] <= {out_sof_o, out_eol_o, out_eof_o, out_data_o};
      n_got <= n_got + 1;
    end
  end
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp)
      begin
        mismatches = mismatches + 1;
        $display("BAD at %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task results;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      k = 0;
      do
      begin
        @(posedge clk_i);
        k = k + 1;
      end
      while (pready_o !== 1'b1 && k < 20);
      if (pready_o !== 1'b1)
      begin
        chk(32'h0, 32'h1);
        results;
      end
      rdv = prdata_o;
      errv = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      chk(rdv, e);
    end
  endtask
  // poke rewrites the mirror bits while the frame runs
  task frame(input [10:0] w, input [10:0] h, input [10:0] c0, input [10:0] r0, input [3:0] ctl, input poke);
    integer k, x, y;
    reg [10:0] c, r;
    reg [15:0] e;
    reg [2:0] f;
    begin
      wr(`OFS_ROI_W, w);
      wr(`OFS_ROI_H, h);
      wr(`OFS_ROI_COL, c0);
      wr(`OFS_ROI_ROW, r0);
      wr(`OFS_CTRL, ctl);
      n_got = 0;
      @(posedge clk_i);
      frame_start_i <= 1'b1;
      @(posedge clk_i);
      frame_start_i <= 1'b0;
      if (poke)
        wr(`OFS_CTRL, ctl ^ 4'h3);
      k = 0;
      do
      begin
        @(posedge clk_i);
        #1;
        k = k + 1;
      end
      while (busy_o !== 1'b0 && k < 3000);
      if (busy_o !== 1'b0)
      begin
        chk(32'h0, 32'h1);
        results;
      end
      chk(n_got, w * h);
      for (y = 0; y < h; y = y + 1)
        for (x = 0; x < w; x = x + 1)
        begin
          c = ctl[0] ? 11'h4FF - (c0 + x) : c0 + x;
          r = ctl[1] ? 11'h3FF - (r0 + y) : r0 + y;
          e = ctl[2] ? {8'h00, c[7:0]} : {c[7:0], r[7:0]};
          f = {x == 0 && y == 0, x == w - 1, x == w - 1 && y == h - 1};
          chk(got[y * w + x], {f, e});
        end
    end
  endtask
  task t_regs;
    begin
      rd(`OFS_SENSOR_W, 32'h500);
      rd(`OFS_SENSOR_H, 32'h400);
      wr(`OFS_SENSOR_W, 32'h5);
      rd(`OFS_SENSOR_W, 32'h500);
      rd(`OFS_DYN_MIN, 32'h0);
      rd(8'h80, 32'h0);
      chk(errv, 32'h1);
      // writes are dropped while the enable is low
      ce_i <= 1'b0;
      wr(`OFS_ROI_COL, 32'h5);
      ce_i <= 1'b1;
      rd(`OFS_ROI_COL, 32'h0);
      $display("regs test done");
    end
  endtask
  task t_bin;
    begin
      wr(`OFS_ROW_MERGE, 32'h2);
      rd(`OFS_MAX_COLS, 32'h280);
      wr(`OFS_COL_MERGE, 32'h4);
      rd(`OFS_MAX_ROWS, 32'h100);
      wr(`OFS_ROI_W, 32'h7);
      wr(`OFS_ROI_ROW, 32'h9);
      rd(`OFS_MAX_COLS, 32'h280);
      rd(`OFS_MAX_ROWS, 32'h100);
      // decimation above 1 switches binning off
      wr(`OFS_HDEC, 32'h4);
      rd(`OFS_MAX_COLS, 32'h140);
      wr(`OFS_VDEC, 32'h2);
      rd(`OFS_MAX_ROWS, 32'h200);
      wr(`OFS_HDEC, 32'h1);
      wr(`OFS_VDEC, 32'h1);
      // second engine stacks on the first
      wr(`OFS_CTRL, 32'h8);
      wr(`OFS_ROW_MERGE, 32'h2);
      rd(`OFS_MAX_COLS, 32'h140);
      wr(`OFS_ROW_MERGE, 32'h1);
      wr(`OFS_CTRL, 32'h0);
      wr(`OFS_ROW_MERGE, 32'h1);
      wr(`OFS_COL_MERGE, 32'h1);
      rd(`OFS_MAX_COLS, 32'h500);
      $display("binning test done");
    end
  endtask
  task t_mirror;
    integer m;
    begin
      stall <= 1'b1;
      lag <= 4'h2;
      wr(`OFS_PIXFMT, 32'h4);
      for (m = 0; m < 4; m = m + 1)
      begin
        frame(11'h3, 11'h2, 11'h2, 11'h4, m, 1'b0);
        rd(`OFS_FILTER, m + 1);
      end
      // odd offsets cancel both mirror swaps
      frame(11'h2, 11'h2, 11'h3, 11'h5, 4'h3, 1'b1);
      rd(`OFS_FILTER, 32'h1);
      stall <= 1'b0;
      lag <= 4'h0;
      $display("mirror test done");
    end
  endtask
  task t_formats;
    integer f;
    begin
      for (f = 0; f < 9; f = f + 1)
      begin
        wr(`OFS_PIXFMT, f);
        frame(11'h1, 11'h1, 11'h0, 11'h0, 4'h0, 1'b0);
        rd(`OFS_PIX_SIZE, f == 2 ? 32'h18 : (f == 1 || f > 6) ? 32'h10 : 32'h8);
        rd(`OFS_FILTER, f > 2 ? 32'h1 : 32'h0);
        rd(`OFS_DYN_MAX, (f == 1 || f > 6) ? 32'hFFF0 : 32'hFF);
      end
      wr(`OFS_PIXFMT, 32'h0);
      frame(11'h2, 11'h1, 11'h6, 11'h1, 4'h4, 1'b0);
      $display("format test done");
    end
  endtask
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_regs;
    t_bin;
    t_mirror;
    t_formats;
    results;
  end
endmodule
